/* File: include/adcsq_pkg.sv */
// Package: constants, modes, states and carriers for the ADC sequencer control block
package adcsq_pkg;

   // ==========================================================
   // Register map (word offsets are byte addresses)
   // ==========================================================
   localparam logic [7:0] ADDR_CTRL    = 8'h00; // Mode, enable, channel select
   localparam logic [7:0] ADDR_TIMING  = 8'h04; // Enable delay and sample time
   localparam logic [7:0] ADDR_STATUS  = 8'h08; // Busy, done, current channel
   localparam logic [7:0] ADDR_SINGLE  = 8'h0c; // Last single-channel result
   localparam logic [7:0] ADDR_RES0    = 8'h40; // First per-channel result word
   localparam logic [7:0] ADDR_RES_END = 8'hbc; // Last per-channel result word

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTRL_EN_BIT    = 0;  // Converter enable
   localparam int CTRL_CONT_BIT  = 1;  // Continuous single-channel
   localparam int CTRL_MODE_LSB  = 2;  // Mode field, 2 bits
   localparam int CTRL_CH_LSB    = 8;  // Channel select, 5 bits
   localparam int TIM_EN_LSB     = 0;  // Enable delay, 16 bits
   localparam int TIM_SMP_LSB    = 16; // Sample time, 16 bits
   localparam int STAT_BUSY_BIT  = 0;  // Sequencing in progress
   localparam int STAT_DONE_BIT  = 1;  // Sticky completion flag
   localparam int STAT_CH_LSB    = 8;  // Channel under conversion

   // ==========================================================
   // Widths, counts and reset values
   // ==========================================================
   localparam int RES_W    = 10;                  // Result width
   localparam int CH_W     = 5;                   // Channel select width
   localparam int NUM_CH   = 32;                  // Multiplexer inputs
   localparam int AUTO_LAST = 10;                 // Last auto-sequenced channel
   localparam int CONV_CYC = 12;                  // Conversion phase cycles
   localparam int IRQ_CYC  = 2;                   // Completion pulse cycles
   localparam int DLY_W    = 16;                  // Programmable delay width
   localparam logic [DLY_W-1:0] EN_DLY_RST  = 16'h0010; // Enable delay default
   localparam logic [DLY_W-1:0] SMP_DLY_RST = 16'h0020; // Sample time default
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // ==========================================================
   // Modes and states
   // ==========================================================
   typedef enum logic [1:0] {
      MODE_SINGLE     = 2'h0,
      MODE_ROUND_ROBIN = 2'h1,
      MODE_ONE_PASS   = 2'h2
   } adcsq_mode_e;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_ENWAIT  = 5'h02,
      ST_SAMPLE  = 5'h04,
      ST_CONVERT = 5'h08,
      ST_IRQ     = 5'h10
   } adcsq_state_e;

   // Conversion result carrier
   typedef struct packed {
      logic             valid;
      logic [CH_W-1:0]  ch;
      logic [RES_W-1:0] data;
   } adcsq_result_s;

endpackage

/* File: src/adcsq_counter.sv */
// Down counter used for the enable, sample, conversion and interrupt phases
`timescale 1ns/1ps
`default_nettype none

module adcsq_counter #(
   parameter int W = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         load_i,   // Load a new count
   input  wire logic [W-1:0] value_i,  // Cycles to count, 0 acts as 1
   output logic              done_o    // High in the last counted cycle
);

   logic [W-1:0] cnt_reg; // Remaining cycles minus one

   // ==========================================================
   // Count down
   // ==========================================================
   // Load takes value-1 so a count of N expires N cycles after load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (load_i) begin
         cnt_reg <= (value_i == '0) ? '0 : W'(value_i - W'(1));
      end else if (cnt_reg != '0) begin
         cnt_reg <= W'(cnt_reg - W'(1));
      end
   end

   // Done reads only the count: the sequencer's load depends on done, so
   // gating done by load would close a combinational loop
   assign done_o = (cnt_reg == '0);

endmodule

`default_nettype wire

/* File: src/adcsq_ctrl.sv */
// ADC sequencer control: Wishbone registers, phase sequencer and SAR handshake
//
// Function
// R01 - Three modes: single, round robin, one pass
// R02 - Single mode converts chosen channel, then interrupts
// R03 - Enable delay after disabled to enabled
// R04 - Programmable sample phase before conversion
// R05 - Conversion phase lasts twelve cycles
// R06 - Result readable, interrupt held two cycles
// R07 - Continuous single restarts after interrupt period
// R08 - Round robin walks auto set from zero
// R09 - Results readable anytime, sequence unaffected
// R10 - Software sets averaging to one first
// R11 - New result overwrites channel's old one
// R12 - Per-channel time about 63.33 us
// R13 - One pass stops after last auto channel
// R14 - One interrupt at one-pass end
// R15 - Only channels 0 to 10 auto-sequenced
// R16 - Software picks divider index per pin use
// R17 - Results are 10-bit unsigned
// R18 - Mode change or disable abandons conversion
// R19 - 5-bit channel select held while sampling
`timescale 1ns/1ps
`default_nettype none

module adcsq_ctrl #(
   parameter int NUM_CH = adcsq_pkg::NUM_CH
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone classic slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [7:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   // SAR converter side
   input  wire logic [adcsq_pkg::RES_W-1:0]   sar_data_i,    // Result bits from converter
   output logic      [adcsq_pkg::CH_W-1:0]    mux_sel_o,     // Input multiplexer select
   output logic                               sar_sample_o,  // Sampling phase active
   output logic                               sar_convert_o, // Conversion phase active
   // Core interrupt
   output logic                               done_irq_o     // Completion interrupt
);

   // ==========================================================
   // Declarations
   // ==========================================================
   localparam int RES_W = adcsq_pkg::RES_W;
   localparam int CH_W  = adcsq_pkg::CH_W;
   localparam int DLY_W = adcsq_pkg::DLY_W;
   localparam logic [CH_W-1:0]  AUTO_LAST_CH = CH_W'(adcsq_pkg::AUTO_LAST);
   localparam logic [DLY_W-1:0] CONV_CNT     = DLY_W'(adcsq_pkg::CONV_CYC);
   localparam logic [DLY_W-1:0] IRQ_CNT      = DLY_W'(adcsq_pkg::IRQ_CYC);

   logic                       en_reg;        // Converter enable
   logic                       cont_reg;      // Continuous single-channel
   adcsq_pkg::adcsq_mode_e     mode_reg;      // Operating mode
   logic [CH_W-1:0]            sel_ch_reg;    // Software channel choice
   logic [DLY_W-1:0]           en_dly_reg;    // Enable delay cycles
   logic [DLY_W-1:0]           smp_dly_reg;   // Sample cycles
   logic                       done_reg;      // Sticky completion flag
   logic [RES_W-1:0]           single_reg;    // Last single-mode result
   logic [RES_W-1:0]           res_mem [NUM_CH]; // Per-channel results
   adcsq_pkg::adcsq_state_e    state_reg;     // Sequencer phase
   adcsq_pkg::adcsq_state_e    state_next;
   logic [CH_W-1:0]            ch_reg;        // Channel under conversion
   logic                       en_d_reg;      // Enable one cycle ago
   logic                       abort;         // Abandon current work
   logic                       load;          // Start a new phase count
   logic [DLY_W-1:0]           load_val;      // Length of next phase
   logic                       phase_done;    // Current phase elapsed
   logic                       wb_req;        // New bus request
   logic                       wr_ctrl;       // Control write strobe
   logic                       wr_done_clr;   // Status write strobe
   logic                       last_auto;     // Last channel of auto set
   logic                       auto_mode;     // Round robin or one pass
   adcsq_pkg::adcsq_result_s   result;        // Finished conversion

   assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl     = wb_req && wb_we_i && (wb_adr_i == adcsq_pkg::ADDR_CTRL);
   assign wr_done_clr = wb_req && wb_we_i && (wb_adr_i == adcsq_pkg::ADDR_STATUS)
                        && wb_sel_i[0] && wb_dat_i[adcsq_pkg::STAT_DONE_BIT];
   assign auto_mode   = (mode_reg != adcsq_pkg::MODE_SINGLE);
   assign last_auto   = (ch_reg == AUTO_LAST_CH);

   // Any control write or disable drops the work in progress
   assign abort = !en_reg || wr_ctrl; // [R18]

   // ==========================================================
   // Control registers
   // ==========================================================
   // Written as whole bytes; only defined mode codes are accepted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_reg     <= 1'b0;
         cont_reg   <= 1'b0;
         mode_reg   <= adcsq_pkg::MODE_SINGLE;
         sel_ch_reg <= '0;
      end else if (wr_ctrl) begin
         if (wb_sel_i[0]) begin
            en_reg   <= wb_dat_i[adcsq_pkg::CTRL_EN_BIT];
            cont_reg <= wb_dat_i[adcsq_pkg::CTRL_CONT_BIT];
            // Reserved mode code keeps the old mode
            case (wb_dat_i[adcsq_pkg::CTRL_MODE_LSB +: 2])
               2'h0:    mode_reg <= adcsq_pkg::MODE_SINGLE;      // [R01]
               2'h1:    mode_reg <= adcsq_pkg::MODE_ROUND_ROBIN; // [R01]
               2'h2:    mode_reg <= adcsq_pkg::MODE_ONE_PASS;    // [R01]
               default: mode_reg <= mode_reg;
            endcase
         end
         if (wb_sel_i[1]) begin
            sel_ch_reg <= wb_dat_i[adcsq_pkg::CTRL_CH_LSB +: CH_W];
         end
      end
   end

   // Timing register, one half-word per delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_dly_reg  <= adcsq_pkg::EN_DLY_RST;
         smp_dly_reg <= adcsq_pkg::SMP_DLY_RST;
      end else if (wb_req && wb_we_i && (wb_adr_i == adcsq_pkg::ADDR_TIMING)) begin
         if (wb_sel_i[1:0] == 2'h3) begin
            en_dly_reg <= wb_dat_i[adcsq_pkg::TIM_EN_LSB +: DLY_W];
         end
         if (wb_sel_i[3:2] == 2'h3) begin
            smp_dly_reg <= wb_dat_i[adcsq_pkg::TIM_SMP_LSB +: DLY_W];
         end
      end
   end

   // Enable history for the rising-edge test
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_d_reg <= 1'b0;
      end else begin
         en_d_reg <= en_reg;
      end
   end

   // ==========================================================
   // Phase counter
   // ==========================================================
   adcsq_counter #(
      .W (DLY_W)
   ) u_phase_cnt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .load_i  (load),
      .value_i (load_val),
      .done_o  (phase_done)
   );

   // ==========================================================
   // Sequencer next state
   // ==========================================================
   always_comb begin
      state_next = state_reg;
      load       = 1'b0;
      load_val   = smp_dly_reg;
      case (state_reg)
         adcsq_pkg::ST_IDLE: begin
            // Start only on a fresh enable
            if (en_reg && !en_d_reg) begin
               state_next = adcsq_pkg::ST_ENWAIT;
               load       = 1'b1;
               load_val   = en_dly_reg; // [R03]
            end
         end
         adcsq_pkg::ST_ENWAIT: begin
            if (phase_done) begin
               state_next = adcsq_pkg::ST_SAMPLE;
               load       = 1'b1;
               load_val   = smp_dly_reg; // [R04]
            end
         end
         adcsq_pkg::ST_SAMPLE: begin
            if (phase_done) begin
               state_next = adcsq_pkg::ST_CONVERT;
               load       = 1'b1;
               load_val   = CONV_CNT; // [R05]
            end
         end
         adcsq_pkg::ST_CONVERT: begin
            if (phase_done) begin
               if (!auto_mode || (mode_reg == adcsq_pkg::MODE_ONE_PASS && last_auto)) begin
                  state_next = adcsq_pkg::ST_IRQ;
                  load       = 1'b1;
                  load_val   = IRQ_CNT; // [R06]
               end else begin
                  // Round robin and mid-pass go straight to the next channel
                  state_next = adcsq_pkg::ST_SAMPLE; // [R08] [R12]
                  load       = 1'b1;
                  load_val   = smp_dly_reg;
               end
            end
         end
         adcsq_pkg::ST_IRQ: begin
            if (phase_done) begin
               if (!auto_mode && cont_reg) begin
                  state_next = adcsq_pkg::ST_SAMPLE; // [R07]
                  load       = 1'b1;
                  load_val   = smp_dly_reg;
               end else begin
                  // One pass halts; re-enable to run again
                  state_next = adcsq_pkg::ST_IDLE; // [R02] [R13]
               end
            end
         end
         default: state_next = adcsq_pkg::ST_IDLE;
      endcase
      if (abort) begin
         state_next = adcsq_pkg::ST_IDLE; // [R18]
         load       = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= adcsq_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Channel stepping
   // ==========================================================
   // Auto modes wrap at the last flagged channel, never above it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch_reg <= '0;
      end else if (state_reg == adcsq_pkg::ST_IDLE) begin
         ch_reg <= auto_mode ? '0 : sel_ch_reg; // [R08] [R02]
      end else if (state_reg == adcsq_pkg::ST_CONVERT && phase_done && auto_mode
                   && !abort) begin
         ch_reg <= last_auto ? '0 : CH_W'(ch_reg + CH_W'(1)); // [R15]
      end
   end

   // ==========================================================
   // Result capture
   // ==========================================================
   // One driver for the whole carrier: valid, channel, data
   assign result = {(state_reg == adcsq_pkg::ST_CONVERT) && phase_done && !abort, ch_reg,
                    sar_data_i}; // [R17]

   // Single-mode result; per-channel results in every mode overwrite in place
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         single_reg <= '0;
      end else if (result.valid && !auto_mode) begin
         single_reg <= result.data; // [R02]
      end
   end

   always_ff @(posedge clk_i) begin
      if (result.valid) begin
         res_mem[result.ch] <= result.data; // [R11]
      end
   end

   // Sticky done flag, a new completion beats a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_reg <= 1'b0;
      end else if (state_next == adcsq_pkg::ST_IRQ && state_reg != adcsq_pkg::ST_IRQ) begin
         done_reg <= 1'b1; // [R14]
      end else if (wr_done_clr) begin
         done_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Converter and interrupt outputs
   // ==========================================================
   // Registered from the next state so outputs align with the phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sar_sample_o  <= 1'b0;
         sar_convert_o <= 1'b0;
         done_irq_o    <= 1'b0;
         mux_sel_o     <= '0;
      end else begin
         sar_sample_o  <= (state_next == adcsq_pkg::ST_SAMPLE);
         sar_convert_o <= (state_next == adcsq_pkg::ST_CONVERT);
         done_irq_o    <= (state_next == adcsq_pkg::ST_IRQ); // [R06]
         // Select follows the channel that enters sampling next
         if (state_next == adcsq_pkg::ST_SAMPLE) begin
            mux_sel_o <= (state_reg == adcsq_pkg::ST_CONVERT && auto_mode)
                         ? (last_auto ? '0 : CH_W'(ch_reg + CH_W'(1)))
                         : ch_reg; // [R19]
         end
      end
   end

   // ==========================================================
   // Wishbone read and acknowledge
   // ==========================================================
   // One wait state; reads never disturb the sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i >= adcsq_pkg::ADDR_RES0 && wb_adr_i <= adcsq_pkg::ADDR_RES_END
                && wb_adr_i[1:0] == 2'h0) begin
               wb_dat_o <= {22'h0, res_mem[5'(wb_adr_i[7:2] - adcsq_pkg::ADDR_RES0[7:2])]}; // [R09]
            end else begin
               case (wb_adr_i)
                  adcsq_pkg::ADDR_CTRL:
                     wb_dat_o <= {19'h0, sel_ch_reg, 4'h0, mode_reg, cont_reg, en_reg};
                  adcsq_pkg::ADDR_TIMING:
                     wb_dat_o <= {smp_dly_reg, en_dly_reg};
                  adcsq_pkg::ADDR_STATUS:
                     wb_dat_o <= {19'h0, ch_reg, 6'h0, done_reg,
                                  (state_reg != adcsq_pkg::ST_IDLE)};
                  adcsq_pkg::ADDR_SINGLE:
                     wb_dat_o <= {22'h0, single_reg};
                  default:
                     wb_dat_o <= adcsq_pkg::UNMAPPED_DATA;
               endcase
            end
         end
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   // Run length of the conversion strobe, so the length check needs no long repeat
   logic [DLY_W-1:0] conv_run_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i || !sar_convert_o) begin
         conv_run_reg <= '0;
      end else begin
         conv_run_reg <= DLY_W'(conv_run_reg + DLY_W'(1));
      end
   end

   // Capture falls in the last strobe cycle, and the strobe drops right after
   sequence s_conv_end;
      (conv_run_reg == DLY_W'(CONV_CNT - DLY_W'(1))) ##1 !sar_convert_o;
   endsequence

   chk_conv_len: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
      result.valid |-> s_conv_end)
      else $error("conversion phase not twelve cycles");

   chk_irq_width: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
      $rose(done_irq_o) && en_reg && !wr_ctrl |=> done_irq_o ##1 (!done_irq_o || abort))
      else $error("interrupt pulse not two cycles");

   chk_irq_after_conv: assert property (@(posedge clk_i) disable iff (rst_i) // [R02]
      $rose(done_irq_o) |-> $past(sar_convert_o))
      else $error("interrupt without preceding conversion");

   chk_auto_range: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
      (auto_mode && sar_sample_o && state_reg == adcsq_pkg::ST_SAMPLE) |-> mux_sel_o <= AUTO_LAST_CH)
      else $error("auto sequence left the flagged channels");

   chk_rr_no_irq: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
      (mode_reg == adcsq_pkg::MODE_ROUND_ROBIN && $stable(mode_reg)) |=> !$rose(done_irq_o))
      else $error("round robin raised an interrupt");

   chk_abort_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
      !en_reg |=> state_reg == adcsq_pkg::ST_IDLE ##1 !sar_sample_o && !sar_convert_o)
      else $error("disable did not abandon the conversion");

   chk_sel_stable: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
      (sar_sample_o && $past(sar_sample_o)) |-> $stable(mux_sel_o))
      else $error("channel select moved while sampling");

   chk_cont_restart: assert property (@(posedge clk_i) disable iff (rst_i || abort) // [R07]
      ($fell(done_irq_o) && !$past(abort) && !auto_mode && cont_reg) |-> sar_sample_o)
      else $error("continuous mode did not restart");

   chk_one_pass_end: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
      ($rose(done_irq_o) && mode_reg == adcsq_pkg::MODE_ONE_PASS) |-> mux_sel_o == AUTO_LAST_CH)
      else $error("one pass ended on the wrong channel");

   chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");

endmodule

`default_nettype wire

/* File: sim/adcsq_sar_model.sv */
// Behavioural SAR converter with sample-and-hold on the channel select
`timescale 1ns/1ps
`default_nettype none

module adcsq_sar_model (
   input  wire logic       clk_i,
   input  wire logic [4:0] mux_sel_i,  // Channel from the controller
   input  wire logic       sample_i,   // Sampling phase
   input  wire logic       convert_i,  // Conversion phase
   output logic      [9:0] data_o      // Result bits
);
   // ==========================================================
   // Held channel and filler pattern
   // ==========================================================
   logic [4:0] held;           // Channel caught while sampling
   logic [9:0] junk = 10'h000; // Moves every cycle, seen on data_o only outside conversion

   // Hold the select as the analog switch would
   always @(posedge clk_i) begin
      if (sample_i) begin
         held <= mux_sel_i;
      end
      junk <= junk + 10'h1a7;
   end

   // Result is only meaningful in conversion, so a late capture shows up
   assign data_o = convert_i ? {held, ~held} : junk;
endmodule
`default_nettype wire

/* File: sim/adcsq_ctrl_tb_top.sv */
// Self-checking testbench for the ADC sequencer control block
`timescale 1ns/1ps
`default_nettype none

module adcsq_ctrl_tb_top;
   // ==========================================================
   // Signals and bookkeeping
   // ==========================================================
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, autom = 1'b0;
   logic [7:0]  adr = 8'h00;   // Bus address
   logic [3:0]  bsel = 4'h0;   // Byte lanes
   logic [31:0] wdat = 32'h0;  // Write data
   logic [31:0] rdat;          // Read data
   logic        ack, smp, cnv, irq;
   logic [4:0]  sel, sel_h;    // Select and its value at sample start
   logic [9:0]  sd;            // Converter result bits
   logic [31:0] expq[$];       // Expected read data, oldest first
   int          n_fail = 0, checks = 0, smp_len = 1, n_irq = 0, cs = 0, cc = 0, ci = 0;

   always #10 clk_i = ~clk_i;

   adcsq_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .sar_data_i(sd), .mux_sel_o(sel), .sar_sample_o(smp),
      .sar_convert_o(cnv), .done_irq_o(irq));
   adcsq_sar_model sar (.clk_i(clk_i), .mux_sel_i(sel), .sample_i(smp), .convert_i(cnv),
      .data_o(sd));

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] code(logic [4:0] c);
      return {22'h0, c, ~c};
   endfunction
   function automatic logic [31:0] ctl(logic [1:0] m, logic ct, logic en, logic [4:0] c);
      return {19'h0, c, 4'h0, m, ct, en};
   endfunction
   task automatic finish_test(logic to);
      if (to) n_fail++;
      if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   // Classic single cycle; hold everything until ack is seen
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      int i;
      cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
      bsel <= 4'hf;
      i = 0;
      do begin @(posedge clk_i); i++; end while (ack !== 1'b1 && i < 50);
      if (i >= 50) finish_test(1'b1);
      cyc <= 1'b0;
      bsel <= 4'h0;
      @(posedge clk_i);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wirq(int n);
      for (int i = 0; i < 20000 && n_irq < n; i++) @(posedge clk_i);
      if (n_irq < n) finish_test(1'b1);
   endtask

   // ==========================================================
   // Output watcher: read data and phase lengths
   // ==========================================================
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) chk("rdata", expq.pop_front(), rdat);
      cs <= smp ? cs + 1 : 0;
      cc <= cnv ? cc + 1 : 0;
      ci <= irq ? ci + 1 : 0;
      if (smp && cs == 0) sel_h <= sel;
      if (smp && cs != 0) chk("mux_hold", sel_h, sel);
      if (smp && autom) chk("auto_ch", 1, 32'(sel <= 5'd10));
      // Only a phase that hands over to the next is whole; an abandoned one is cut
      if (!smp && cs != 0 && cnv) chk("sample_len", smp_len, cs);
      if (!cnv && cc != 0 && (irq || smp)) chk("convert_len", adcsq_pkg::CONV_CYC, cc);
      if (!irq && ci != 0) begin
         chk("irq_len", 2, ci);
         n_irq <= n_irq + 1;
      end
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      int k;
      logic [4:0] ch;
      k = $urandom(32'h1b527836);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(adcsq_pkg::ADDR_TIMING, {adcsq_pkg::SMP_DLY_RST, adcsq_pkg::EN_DLY_RST});
      rd(8'h24, adcsq_pkg::UNMAPPED_DATA);
      smp_len = 3 + ($urandom % 4);
      bus(1'b1, adcsq_pkg::ADDR_TIMING, {16'(smp_len), 16'h0002});
      ch = 5'(11 + $urandom % 21);
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b1, ch));
      wirq(1);
      rd(adcsq_pkg::ADDR_SINGLE, code(ch));
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, ch));
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h0, 1'b1, 1'b1, ch));
      wirq(3);
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, ch));
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b1, ch));
      // Land the disable inside the conversion phase, past the sample time
      repeat (smp_len + 4) @(posedge clk_i);
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, ch));
      k = n_irq;
      repeat (100) @(posedge clk_i);
      chk("abort_irq", k, n_irq);
      autom <= 1'b1;
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h2, 1'b0, 1'b1, 5'h0));
      wirq(k + 1);
      for (int n = 0; n <= 10; n++) rd(8'(adcsq_pkg::ADDR_RES0 + 4 * n), code(5'(n)));
      k = n_irq;
      repeat (300) @(posedge clk_i);
      chk("one_pass_stop", k, n_irq);
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 5'h0));
      bus(1'b1, adcsq_pkg::ADDR_CTRL, ctl(2'h1, 1'b0, 1'b1, 5'h0)); // round robin, keeps sequencing
      repeat (400) @(posedge clk_i);
      rd(8'(adcsq_pkg::ADDR_RES0 + 12), code(5'd3));
      chk("rr_no_irq", k, n_irq);
      finish_test(1'b0);
   end
endmodule
`default_nettype wire
